// [bench/param_point_table_write_decoder_tb_top.sv]
// Purpose: Self-checking bench of the write decoder
// Assumes: Host model drives the request words
// Notes: Model checks answers, nv writes, read-back
`timescale 1ns/100ps
`default_nettype none

module param_point_table_write_decoder_tb_top;
    localparam int P_CNT = 200;
    logic mclk_i, arst_n_i, cmd_valid, resp_valid, ready, nv_wr;
    logic [15:0] code, data, limit, resp, nv_data, prd;
    logic [9:0] nv_addr;
    logic [1:0] rd_group;
    logic [7:0] rd_idx;
    logic [31:0] ptrd;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 46;
    int grp_m, pend_m, pn_m, plo_m, lim_m;
    int pram[1024];
    int pt[256];
    int mx[4] = '{16'h7FFF, 16'h0100, 16'h7FFF, 16'h7FFF};
    int exp_q[$];
    int nv_q[$];

    ppt_host_model host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .code_o(code),
        .data_o(data));
    ppt_write_decoder #(.MAX_G1(16'h0100), .POINT_COUNT(P_CNT)) dut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid),
        .instruction_code_word_i(code), .writing_data_word_i(data),
        .write_range_limit_param_i(limit), .resp_valid_o(resp_valid),
        .response_code_word_o(resp), .ready_o(ready), .group_sel_o(),
        .lower_pending_o(), .nv_wr_o(nv_wr), .nv_addr_o(nv_addr), .nv_data_o(nv_data),
        .rd_group_i(rd_group), .rd_param_i(rd_idx), .rd_point_i(rd_idx),
        .param_rd_data_o(prd), .point_rd_data_o(ptrd));

    initial begin
        mclk_i = 1'h0;
        forever #10 mclk_i = ~mclk_i;
    end

    // ----------------------------------------------------------------
    // Tasks and reference model
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic set_lim(input logic [15:0] v);
        @(posedge mclk_i);
        limit <= v;
        lim_m = v;
    endtask

    task automatic mdl(input int c, input int d);
        int cl, n, r;
        cl = c >> 8;
        n = c & 255;
        r = 16'h0010;
        if (c == 16'h8200) begin
            r = (d > 3) ? 16'h0030 : 16'h0000;
            if (d <= 3) grp_m = d;
        end else if ((cl == 8'h82 || cl == 8'h83) && n != 0) begin
            if (lim_m[grp_m] == 0) r = 16'h0020;
            else if (d > mx[grp_m]) r = 16'h0030;
            else begin
                r = 16'h0000;
                pram[grp_m * 256 + n] = d;
                if (cl == 8'h83) nv_q.push_back(((grp_m * 256 + n) << 16) | d);
            end
        end else if (cl == 8'h84 && n != 0) begin
            r = (n > P_CNT) ? 16'h0020 : 16'h0000;
            if (n <= P_CNT && pend_m == 1 && pn_m == n) begin
                pt[n] = (d << 16) | plo_m;
                pend_m = 0;
            end else if (n <= P_CNT) begin
                pend_m = 1;
                pn_m = n;
                plo_m = d;
            end
        end
        exp_q.push_back(r);
    endtask

    task automatic req(input int c, input int d);
        mdl(c, d);
        host.put(c[15:0], d[15:0]);
        host.idle();
    endtask

    task automatic pos(input int c, input int lo, input int hi);
        mdl(c, lo);
        host.put(c[15:0], lo[15:0]);
        req(c, hi);
    endtask

    // Answers and nv writes against the model
    always @(posedge mclk_i) begin
        if (resp_valid === 1'h1) chk(resp, exp_q.size() > 0 ? exp_q.pop_front() : -1);
        if (nv_wr === 1'h1) chk({nv_addr, nv_data}, nv_q.size() > 0 ? nv_q.pop_front() : -1);
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int i, r;
        int und[6] = '{16'h8500, 16'h8400, 16'h8300, 16'h8101, 16'h0000, 16'hFFFF};
        arst_n_i = 1'h0;
        limit = 16'h000F;
        lim_m = 15;
        rd_group = 2'h0;
        rd_idx = 8'h00;
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1'h1;
        host.put(16'h8201, 16'h0001);
        host.idle();
        for (i = 0; i < 3000 && ready !== 1'h1; i++) @(posedge mclk_i);
        if (ready !== 1'h1) begin
            n_fail++;
            wrap_up();
        end
        $display("test startup finished");
        for (i = 0; i < 5; i++) begin
            req(16'h8200, i);
            req(16'h8201 + i, 16'h0011 * i);
        end
        req(16'h82FF, 16'h7FFF);
        req(16'h8200, 16'hFFFF);
        $display("test group finished");
        set_lim(16'h000A);
        req(16'h8200, 0);
        req(16'h8205, 1);
        req(16'h8305, 1);
        req(16'h8200, 1);
        req(16'h8206, 16'h0100);
        req(16'h8207, 16'h0101);
        req(16'h8306, 16'h0100);
        set_lim(16'h000F);
        req(16'h8200, 3);
        req(16'h83FF, 16'h7FFF);
        req(16'h8301, 16'h8000);
        $display("test limits finished");
        pos(16'h8401, 16'hAAAA, 16'h5555);
        pos(16'h84C8, 16'h1234, 16'h8765);
        req(16'h84C9, 16'h0001);
        req(16'h8402, 16'h1111);
        req(16'h8203, 16'h0033);
        req(16'h8402, 16'h2222);
        req(16'h8403, 16'h3333);
        pos(16'h8404, 16'h4444, 16'h5555);
        foreach (und[k]) req(und[k], 0);
        $display("test point finished");
        for (i = 0; i < 80; i++) begin
            r = $random(seed);
            if (i % 10 == 0) set_lim(16'((r >> 16) | 1));
            req(16'h8200 + (r & 16'h03FF), r[31] ? r[31:16] : r[31:16] & 16'h01FF);
        end
        $display("test random finished");
        for (i = 0; i < 1024; i++) begin
            @(posedge mclk_i);
            {rd_group, rd_idx} <= 10'(i);
            repeat (2) @(posedge mclk_i);
            #1;
            chk(prd, pram[i]);
            if (i < 256) chk(ptrd, pt[i]);
        end
        repeat (3) @(posedge mclk_i);
        chk(exp_q.size(), 0);
        chk(nv_q.size(), 0);
        $display("test readback finished");
        wrap_up();
    end

endmodule // param_point_table_write_decoder_tb_top

`default_nettype wire

// [bench/ppt_host_model.sv]
// Purpose: Host station model issuing write requests
// Assumes: Requests launched just after a rising edge
// Notes: Released words show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none

module ppt_host_model (
    // Clock
    input wire logic mclk_i,
    // Request words
    output logic cmd_valid_o,
    output logic [15:0] code_o,
    output logic [15:0] data_o
);
    initial {cmd_valid_o, code_o, data_o} = 33'h0;

    // Code in the instruction word, hex value in the data word
    task automatic put(input logic [15:0] c, input logic [15:0] d);
        @(posedge mclk_i);
        cmd_valid_o <= 1'h1;
        code_o <= c;
        data_o <= d;
    endtask

    task automatic idle();
        @(posedge mclk_i);
        cmd_valid_o <= 1'h0;
        code_o <= ~code_o;
        data_o <= ~data_o;
    endtask

endmodule // ppt_host_model

`default_nettype wire

// [bench/ppt_write_decoder_monitor.sv]
// Purpose: Port-level checks of the write decoder
// Assumes: Sees only the decoder's top-level ports
// Notes: Bound to every decoder instance
`timescale 1ns/100ps
`default_nettype none

module ppt_decoder_checker #(
    parameter logic [15:0] MAX_G0 = 16'h7FFF,
    parameter logic [15:0] MAX_G1 = 16'h7FFF,
    parameter logic [15:0] MAX_G2 = 16'h7FFF,
    parameter logic [15:0] MAX_G3 = 16'h7FFF,
    parameter int POINT_COUNT = 255
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Request
    input wire logic cmd_valid_i,
    input wire logic [15:0] instruction_code_word_i,
    input wire logic [15:0] writing_data_word_i,
    input wire logic [15:0] write_range_limit_param_i,
    // Answer and status
    input wire logic resp_valid_o,
    input wire logic [15:0] response_code_word_o,
    input wire logic ready_o,
    input wire logic [1:0] group_sel_o,
    input wire logic lower_pending_o,
    input wire logic nv_wr_o,
    input wire logic [9:0] nv_addr_o,
    input wire logic [15:0] nv_data_o
);
    logic take, prm, ok;
    logic [7:0] cls, num;
    logic [15:0] mx;
    assign take = cmd_valid_i & ready_o;
    assign cls = instruction_code_word_i[15:8];
    assign num = instruction_code_word_i[7:0];
    assign prm = take && (cls == 8'h82 || cls == 8'h83) && num != 8'h00;
    assign mx = group_sel_o == 2'h0 ? MAX_G0 : group_sel_o == 2'h1 ? MAX_G1 :
                group_sel_o == 2'h2 ? MAX_G2 : MAX_G3;
    assign ok = prm && write_range_limit_param_i[group_sel_o] && writing_data_word_i <= mx;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    resp_pulse_a: assert property (take |=> resp_valid_o)
        else $error("request not answered");
    no_resp_a: assert property (!take |=> !resp_valid_o)
        else $error("stray answer");
    undef_code_a: assert property (take && (cls < 8'h82 || cls > 8'h84 ||
        (num == 8'h00 && cls != 8'h82)) |=> response_code_word_o == 16'h0010)
        else $error("undefined code not flagged");
    grp_sel_a: assert property (take && instruction_code_word_i == 16'h8200 &&
        writing_data_word_i < 16'h0004 |=> group_sel_o == $past(writing_data_word_i[1:0]))
        else $error("group select not taken");
    grp_bad_a: assert property (take && instruction_code_word_i == 16'h8200 &&
        writing_data_word_i > 16'h0003 |=> response_code_word_o == 16'h0030 && $stable(group_sel_o))
        else $error("bad group select accepted");
    range_err_a: assert property (prm && !write_range_limit_param_i[group_sel_o]
        |=> response_code_word_o == 16'h0020 && !nv_wr_o)
        else $error("disabled group written");
    value_err_a: assert property (prm && write_range_limit_param_i[group_sel_o]
        && writing_data_word_i > mx |=> response_code_word_o == 16'h0030 && !nv_wr_o)
        else $error("bad value not refused");
    ram_ok_a: assert property (ok && cls == 8'h82 |=>
        response_code_word_o == 16'h0000 && !nv_wr_o)
        else $error("RAM write misanswered");
    nv_write_a: assert property (ok && cls == 8'h83 |=> nv_wr_o &&
        nv_addr_o == {$past(group_sel_o), $past(num)} && nv_data_o == $past(writing_data_word_i))
        else $error("nv write wrong");
    pend_set_a: assert property (take && cls == 8'h84 && num != 8'h00 &&
        num <= POINT_COUNT && !lower_pending_o |=> lower_pending_o)
        else $error("lower half not held");
    pt_range_a: assert property (take && cls == 8'h84 && num > POINT_COUNT |=>
        response_code_word_o == 16'h0020 && $stable(lower_pending_o))
        else $error("bad point number taken");

    cover property (nv_wr_o);
    cover property (prm && !write_range_limit_param_i[group_sel_o]);
    cover property (take && cls == 8'h84 && lower_pending_o);

endmodule // ppt_decoder_checker

bind ppt_write_decoder ppt_decoder_checker #(.MAX_G0(MAX_G0), .MAX_G1(MAX_G1),
    .MAX_G2(MAX_G2), .MAX_G3(MAX_G3), .POINT_COUNT(POINT_COUNT)) u_chk (
    .mclk_i, .arst_n_i, .cmd_valid_i, .instruction_code_word_i, .writing_data_word_i,
    .write_range_limit_param_i, .resp_valid_o, .response_code_word_o, .ready_o,
    .group_sel_o, .lower_pending_o, .nv_wr_o, .nv_addr_o, .nv_data_o);

`default_nettype wire

// [include/ppt_defs.svh]
// Purpose: Constants of the write decoder
// Assumes: Included by bare name wherever the codes are needed
// Notes: Definitions only
`ifndef PPT_DEFS_SVH
`define PPT_DEFS_SVH

// ----------------------------------------------------------------
// Word widths
// ----------------------------------------------------------------
`define PPT_WORD_W 16
`define PPT_GROUP_W 2
`define PPT_INDEX_W 8

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define PPT_CODE_GRP_SEL 16'h8200
`define PPT_CLASS_RAM 8'h82
`define PPT_CLASS_NV 8'h83
`define PPT_CLASS_POINT 8'h84
`define PPT_INDEX_NONE 8'h00
`define PPT_GROUP_LAST 16'h0003

// ----------------------------------------------------------------
// Response codes
// ----------------------------------------------------------------
`define PPT_RESP_OK 16'h0000
`define PPT_RESP_UNDEF 16'h0010
`define PPT_RESP_RANGE 16'h0020
`define PPT_RESP_VALUE 16'h0030

// ----------------------------------------------------------------
// Reset value and limit bit position
// ----------------------------------------------------------------
`define PPT_GROUP_RESET 2'h0
`define PPT_LIMIT_BIT_POS 0

`endif

// [include/ppt_pkg.sv]
// Purpose: Types of the write decoder
// Assumes: Compiled before every design file
// Notes: Numbers live in ppt_defs.svh
package ppt_pkg;

    // Operation class picked from the instruction code
    typedef enum logic [2:0] {
        op_none,
        op_group,
        op_ram,
        op_nv,
        op_point,
        op_undef
    } ppt_op_type;

    // Which half of a position word the next point write carries
    typedef enum logic {
        half_lower,
        half_upper
    } ppt_half_type;

endpackage

// [rtl/ppt_limit_check.sv]
// Purpose: Range and value check of a parameter write
// Assumes: Combinational, one group selection at a time
// Notes: Range fault is reported ahead of a value fault
`timescale 1ns/100ps
`default_nettype none

`include "ppt_defs.svh"

module ppt_limit_check import ppt_pkg::*; #(
    parameter logic [15:0] MAX_G0 = 16'h7FFF,
    parameter logic [15:0] MAX_G1 = 16'h7FFF,
    parameter logic [15:0] MAX_G2 = 16'h7FFF,
    parameter logic [15:0] MAX_G3 = 16'h7FFF,
    parameter logic [7:0] COUNT_G0 = 8'hFF,
    parameter logic [7:0] COUNT_G1 = 8'hFF,
    parameter logic [7:0] COUNT_G2 = 8'hFF,
    parameter logic [7:0] COUNT_G3 = 8'hFF
) (
    // Request
    input wire logic [`PPT_GROUP_W-1:0] group_i,
    input wire logic [`PPT_INDEX_W-1:0] index_i,
    input wire logic [`PPT_WORD_W-1:0] data_i,
    input wire logic [`PPT_WORD_W-1:0] limit_i,
    // Verdict
    output logic [`PPT_WORD_W-1:0] resp_o
);

    logic [15:0] max_val;
    logic [7:0] max_idx;

    // ----------------------------------------------------------------
    // Per-group limits
    // ----------------------------------------------------------------
    always_comb begin
        case (group_i)
            2'h0: begin
                max_val = MAX_G0;
                max_idx = COUNT_G0;
            end
            2'h1: begin
                max_val = MAX_G1;
                max_idx = COUNT_G1;
            end
            2'h2: begin
                max_val = MAX_G2;
                max_idx = COUNT_G2;
            end
            default: begin
                max_val = MAX_G3;
                max_idx = COUNT_G3;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Verdict
    // ----------------------------------------------------------------
    always_comb begin
        if (!limit_i[`PPT_LIMIT_BIT_POS + group_i] || index_i > max_idx) begin
            resp_o = `PPT_RESP_RANGE; // [R7]
        end else if (data_i > max_val) begin
            resp_o = `PPT_RESP_VALUE; // [R8]
        end else begin
            resp_o = `PPT_RESP_OK;
        end
    end

endmodule // ppt_limit_check

`default_nettype wire

// [rtl/ppt_word_ram.sv]
// Purpose: Volatile word store, cleared by a sweep after reset
// Assumes: One write port, one registered read port
// Notes: Writes are ignored while the sweep runs
`timescale 1ns/100ps
`default_nettype none

module ppt_word_ram #(
    parameter int WIDTH = 16,
    parameter int ADDR_BITS = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [ADDR_BITS-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input wire logic [ADDR_BITS-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o,
    // Status
    output logic busy_o
);

    if (WIDTH < 1 || ADDR_BITS < 1 || ADDR_BITS > 16) begin : g_bad_size
        $error("ppt_word_ram: unsupported size");
    end

    logic [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];
    logic [ADDR_BITS-1:0] sweep;

    // ----------------------------------------------------------------
    // Power-up clear sweep
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sweep <= '0;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            sweep <= sweep + 1'b1;
            if (sweep == {ADDR_BITS{1'b1}}) begin
                busy_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (busy_o) begin
            mem[sweep] <= '0;
        end else if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule // ppt_word_ram

`default_nettype wire

// [rtl/ppt_write_decoder.sv]
// Purpose: Decodes parameter and point-table write codes from the link words
// Assumes: Link words are synchronous to mclk_i and qualified by cmd_valid_i
// Notes: Nonvolatile store sits outside, fed by the nv port
//
// Contract
// R1: The host puts the write code in the instruction word and the value in the data word.
// R2: An undefined write code stores an error code in the response word.
// R3: A group-select write chooses group 0 to 3, held until changed.
// R4: Codes 8201h up store the value into the selected group in volatile RAM.
// R5: Parameter RAM and nonvolatile writes target the most recently selected group.
// R6: The low byte of the code is the parameter number, 1 to 255.
// R7: A code outside the range allowed by the write range limit returns an error.
// R8: A value outside the parameter's setting range returns an error and is not stored.
// R9: Codes 8301h up store the value into the selected group for nonvolatile keeping.
// R10: Nonvolatile writes persist across power cycles, RAM writes do not.
// R11: Codes 8401h up store position data into volatile point entries 1 to 255.
// R12: A position is formed from a lower and an upper 16-bit half.
// R13: The host writes the lower half first, then the upper half.
// R14: The host converts values to hexadecimal before writing them.
// R15: The value is taken from the data word.
// R16: The upper byte of the code picks RAM, nonvolatile or point-table class.
`timescale 1ns/100ps
`default_nettype none

`include "ppt_defs.svh"

module ppt_write_decoder import ppt_pkg::*; #(
    parameter logic [15:0] MAX_G0 = 16'h7FFF,
    parameter logic [15:0] MAX_G1 = 16'h7FFF,
    parameter logic [15:0] MAX_G2 = 16'h7FFF,
    parameter logic [15:0] MAX_G3 = 16'h7FFF,
    parameter int POINT_COUNT = 255
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Link request words
    input wire logic cmd_valid_i,
    input wire logic [`PPT_WORD_W-1:0] instruction_code_word_i,
    input wire logic [`PPT_WORD_W-1:0] writing_data_word_i,
    // Write range limit setting
    input wire logic [`PPT_WORD_W-1:0] write_range_limit_param_i,
    // Link answer words
    output logic resp_valid_o,
    output logic [`PPT_WORD_W-1:0] response_code_word_o,
    // Status
    output logic ready_o,
    output logic [`PPT_GROUP_W-1:0] group_sel_o,
    output logic lower_pending_o,
    // Nonvolatile store port
    output logic nv_wr_o,
    output logic [`PPT_GROUP_W+`PPT_INDEX_W-1:0] nv_addr_o,
    output logic [`PPT_WORD_W-1:0] nv_data_o,
    // Read-back of volatile stores
    input wire logic [`PPT_GROUP_W-1:0] rd_group_i,
    input wire logic [`PPT_INDEX_W-1:0] rd_param_i,
    input wire logic [`PPT_INDEX_W-1:0] rd_point_i,
    output logic [`PPT_WORD_W-1:0] param_rd_data_o,
    output logic [2*`PPT_WORD_W-1:0] point_rd_data_o
);

    if (POINT_COUNT < 1 || POINT_COUNT > 255) begin : g_bad_count
        $error("ppt_write_decoder: POINT_COUNT must be 1 to 255");
    end

    localparam logic [7:0] POINT_LAST = 8'(POINT_COUNT);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ppt_op_type op_class;
    ppt_half_type half;
    ppt_half_type next_half;
    logic [7:0] code_class;
    logic [7:0] code_index;
    logic [15:0] data;
    logic [15:0] chk_resp;
    logic [15:0] next_resp;
    logic accept;
    logic take;
    logic param_we;
    logic point_we;
    logic busy_param;
    logic busy_point;
    logic [7:0] pend_index;
    logic [15:0] lower_hold;

    // Split the link words
    assign code_class = instruction_code_word_i[15:8]; // [R1]
    assign code_index = instruction_code_word_i[7:0]; // [R6]
    assign data = writing_data_word_i; // [R15] [R14]

    // ----------------------------------------------------------------
    // Code decode
    // ----------------------------------------------------------------
    always_comb begin
        op_class = op_undef;
        if (!cmd_valid_i) begin
            op_class = op_none;
        end else if (instruction_code_word_i == `PPT_CODE_GRP_SEL) begin
            op_class = op_group; // [R3]
        end else if (code_index != `PPT_INDEX_NONE) begin
            case (code_class) // [R16]
                `PPT_CLASS_RAM: begin
                    op_class = op_ram;
                end
                `PPT_CLASS_NV: begin
                    op_class = op_nv;
                end
                `PPT_CLASS_POINT: begin
                    op_class = op_point;
                end
                default: begin
                    op_class = op_undef;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Limit check for parameter writes
    // ----------------------------------------------------------------
    ppt_limit_check #(
        .MAX_G0(MAX_G0),
        .MAX_G1(MAX_G1),
        .MAX_G2(MAX_G2),
        .MAX_G3(MAX_G3)
    ) u_check (
        .group_i(group_sel_o),
        .index_i(code_index),
        .data_i(data),
        .limit_i(write_range_limit_param_i),
        .resp_o(chk_resp)
    );

    // ----------------------------------------------------------------
    // Response selection
    // ----------------------------------------------------------------
    always_comb begin
        case (op_class)
            op_undef: begin
                next_resp = `PPT_RESP_UNDEF; // [R2]
            end
            op_group: begin
                if (data > `PPT_GROUP_LAST) begin
                    next_resp = `PPT_RESP_VALUE;
                end else begin
                    next_resp = `PPT_RESP_OK;
                end
            end
            op_ram, op_nv: begin
                next_resp = chk_resp; // [R7] [R8]
            end
            op_point: begin
                if (code_index > POINT_LAST) begin
                    next_resp = `PPT_RESP_RANGE;
                end else begin
                    next_resp = `PPT_RESP_OK;
                end
            end
            default: begin
                next_resp = `PPT_RESP_OK;
            end
        endcase
    end

    // Requests are only taken once both stores are cleared
    assign take = cmd_valid_i && ready_o;
    assign accept = take && (next_resp == `PPT_RESP_OK); // [R8]
    assign param_we = accept && (op_class == op_ram || op_class == op_nv); // [R4] [R9]

    // ----------------------------------------------------------------
    // Response register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            resp_valid_o <= 1'b0;
            response_code_word_o <= `PPT_RESP_OK;
        end else begin
            resp_valid_o <= take;
            if (take) begin
                response_code_word_o <= next_resp; // [R2]
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !busy_param && !busy_point;
        end
    end

    // ----------------------------------------------------------------
    // Group selection
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            group_sel_o <= `PPT_GROUP_RESET;
        end else if (accept && op_class == op_group) begin
            group_sel_o <= data[`PPT_GROUP_W-1:0]; // [R3] [R5]
        end
    end

    // ----------------------------------------------------------------
    // Nonvolatile store port
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nv_wr_o <= 1'b0;
            nv_addr_o <= '0;
            nv_data_o <= '0;
        end else begin
            nv_wr_o <= accept && op_class == op_nv; // [R9] [R10]
            if (accept && op_class == op_nv) begin
                nv_addr_o <= {group_sel_o, code_index}; // [R5] [R6]
                nv_data_o <= data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Parameter RAM, also refreshed by nonvolatile writes
    // ----------------------------------------------------------------
    ppt_word_ram #(
        .WIDTH(`PPT_WORD_W),
        .ADDR_BITS(`PPT_GROUP_W + `PPT_INDEX_W)
    ) u_param_ram (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .wr_en_i(param_we),
        .wr_addr_i({group_sel_o, code_index}), // [R4] [R5] [R6]
        .wr_data_i(data),
        .rd_addr_i({rd_group_i, rd_param_i}),
        .rd_data_o(param_rd_data_o),
        .busy_o(busy_param)
    );

    // ----------------------------------------------------------------
    // Point-table half pairing
    // ----------------------------------------------------------------
    // Upper half commits only when it names the entry of the held lower half
    assign point_we = accept && op_class == op_point && half == half_upper
        && code_index == pend_index; // [R12] [R13]

    always_comb begin
        next_half = half;
        if (accept && op_class == op_point) begin
            if (point_we) begin
                next_half = half_lower;
            end else begin
                next_half = half_upper;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            half <= half_lower;
            pend_index <= `PPT_INDEX_NONE;
            lower_hold <= '0;
        end else begin
            half <= next_half;
            if (accept && op_class == op_point && !point_we) begin
                pend_index <= code_index; // [R13]
                lower_hold <= data;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lower_pending_o <= 1'b0;
        end else begin
            lower_pending_o <= (next_half == half_upper);
        end
    end

    // ----------------------------------------------------------------
    // Point table, volatile
    // ----------------------------------------------------------------
    ppt_word_ram #(
        .WIDTH(2 * `PPT_WORD_W),
        .ADDR_BITS(`PPT_INDEX_W)
    ) u_point_ram (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .wr_en_i(point_we), // [R11]
        .wr_addr_i(code_index),
        .wr_data_i({data, lower_hold}), // [R12]
        .rd_addr_i(rd_point_i),
        .rd_data_o(point_rd_data_o),
        .busy_o(busy_point)
    );

endmodule // ppt_write_decoder

`default_nettype wire
